// ===== core/sct_pkg.sv
package sct_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] SCT_TIMING_OFF = 12'h000;
    localparam logic [11:0] SCT_STATUS_OFF = 12'h004;

    // ------------------------------------------------------------
    // Timing word fields
    // ------------------------------------------------------------
    localparam int SCT_RDLAT_LSB = 7;
    localparam int SCT_WRW_LSB   = 3;
    localparam int SCT_RFI_LSB   = 0;

    localparam logic [1:0] SCT_RDLAT_RESET = 2'h2;
    localparam logic [1:0] SCT_WRW_RESET   = 2'h0;
    localparam logic [1:0] SCT_RFI_RESET   = 2'h0;

    localparam logic [31:0] SCT_TIMING_RESET = 32'h0000_0100;

    // ------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------
    localparam int SCT_ST_BANK_LSB = 0;
    localparam int SCT_ST_RFI_BIT  = 4;
    localparam int SCT_ST_RD_BIT   = 5;

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam int SCT_CNT_W     = 4;
    localparam int SCT_NUM_BANKS = 4;
    localparam int SCT_RD_PIPE   = 4;

    localparam logic [SCT_CNT_W-1:0] SCT_RFI_CYC0 = 4'h2;
    localparam logic [SCT_CNT_W-1:0] SCT_RFI_CYC1 = 4'h3;
    localparam logic [SCT_CNT_W-1:0] SCT_RFI_CYC2 = 4'h5;
    localparam logic [SCT_CNT_W-1:0] SCT_RFI_CYC3 = 4'h8;

    // ------------------------------------------------------------
    // Commands toward the memory
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SCT_CMD_NOP              = 4'h0,
        SCT_CMD_ROW_OPEN         = 4'h1,
        SCT_CMD_COLUMN_READ      = 4'h2,
        SCT_CMD_COLUMN_STORE     = 4'h3,
        SCT_CMD_COLUMN_STORE_AC  = 4'h4,
        SCT_CMD_BANK_CLOSE       = 4'h5,
        SCT_CMD_REFRESH          = 4'h6,
        SCT_CMD_MODE_SET         = 4'h7,
        SCT_CMD_SELF_EXIT        = 4'h8
    } sct_cmd_t;

    typedef struct packed {
        sct_cmd_t   cmd;
        logic [1:0] bank;
    } sct_req_t;

endpackage

// ===== core/sct_gap_counter.sv
`timescale 1ns/100ps

module sct_gap_counter
    import sct_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 load,
    input  wire logic [SCT_CNT_W-1:0] load_val,
    output wire logic                 idle
);

    logic [SCT_CNT_W-1:0] count_reg;
    logic [SCT_CNT_W-1:0] count_next;

    // ------------------------------------------------------------
    // Down counter, reload wins over decrement
    // ------------------------------------------------------------
    assign count_next = load ? load_val :
                        (count_reg != '0) ? count_reg - 1'b1 : count_reg;
    assign idle       = (count_reg == '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule

// ===== core/sct_spacing.sv
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps


module sct_spacing
    import sct_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        req_valid,
    input  wire sct_req_t    req,
    output logic             req_taken,
    output logic             mem_cmd_valid,
    output sct_req_t         mem_cmd,
    output logic             read_data_strobe,
    output logic [1:0]       area3_read_latency
);

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    function automatic logic [SCT_CNT_W-1:0] wrw_cycles(input logic [1:0] code);
        wrw_cycles = {2'h0, code};
    endfunction

    function automatic logic [SCT_CNT_W-1:0] rfi_cycles(input logic [1:0] code);
        logic [SCT_CNT_W-1:0] val;
        val = SCT_RFI_CYC0;
        unique case (code)
            2'h0: val = SCT_RFI_CYC0;
            2'h1: val = SCT_RFI_CYC1;
            2'h2: val = SCT_RFI_CYC2;
            2'h3: val = SCT_RFI_CYC3;
        endcase
        rfi_cycles = val;
    endfunction

    function automatic logic hit_off(input logic [11:0] addr, input logic [11:0] off);
        hit_off = (addr == off);
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0]             rdlat_reg;
    logic [1:0]             wrw_reg;
    logic [1:0]             rfi_reg;
    logic [31:0]            prdata_reg;
    logic                   pready_reg;
    logic                   pslverr_reg;
    logic                   taken_reg;
    logic                   cmd_valid_reg;
    sct_req_t               cmd_reg;
    logic [SCT_RD_PIPE-1:0] rd_pipe_reg;
    logic                   rd_strobe_reg;
    logic [1:0]             lat_out_reg;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire        acc_phase  = psel & penable;
    wire        hit_timing = hit_off(paddr, SCT_TIMING_OFF);
    wire        hit_status = hit_off(paddr, SCT_STATUS_OFF);
    wire        mapped     = hit_timing | hit_status;
    wire        wr_commit  = acc_phase & pready_reg & pwrite & hit_timing;
    wire        pready_next  = acc_phase & ~pready_reg;
    wire        pslverr_next = pready_next & ~mapped;

    wire [31:0] timing_word;
    wire [31:0] status_word;
    wire [31:0] rd_mux;

    // Only the three fields exist; reserved bits stay zero
    assign timing_word = {23'h0, rdlat_reg, 1'b0, 1'b0, wrw_reg, 1'b0, rfi_reg};
    assign rd_mux      = hit_timing ? timing_word :
                         hit_status ? status_word : 32'h0000_0000;

    // ------------------------------------------------------------
    // Shared settings
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdlat_reg <= SCT_RDLAT_RESET;
            wrw_reg   <= SCT_WRW_RESET;
            rfi_reg   <= SCT_RFI_RESET;
        end else if (wr_commit) begin
            // One copy serves both areas
            rdlat_reg <= pwdata[SCT_RDLAT_LSB +: 2];
            wrw_reg   <= pwdata[SCT_WRW_LSB +: 2];
            rfi_reg   <= pwdata[SCT_RFI_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= (pready_next & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Command classification
    // ------------------------------------------------------------
    wire take_try     = req_valid & ~taken_reg;
    wire is_row_open  = (req.cmd == SCT_CMD_ROW_OPEN);
    wire is_close     = (req.cmd == SCT_CMD_BANK_CLOSE);
    wire is_refresh   = (req.cmd == SCT_CMD_REFRESH);
    wire is_mode_set  = (req.cmd == SCT_CMD_MODE_SET);
    wire is_self_exit = (req.cmd == SCT_CMD_SELF_EXIT);
    wire is_read      = (req.cmd == SCT_CMD_COLUMN_READ);
    wire is_store     = (req.cmd == SCT_CMD_COLUMN_STORE);
    wire is_store_ac  = (req.cmd == SCT_CMD_COLUMN_STORE_AC);

    // ------------------------------------------------------------
    // Per-bank write recovery counters
    // ------------------------------------------------------------
    logic [SCT_NUM_BANKS-1:0] bank_idle;
    logic [SCT_NUM_BANKS-1:0] bank_load;
    logic                     issue;

    genvar b;
    generate
        for (b = 0; b < SCT_NUM_BANKS; b++) begin : g_bank
            // Either store guards both the next open and the next close of its bank
            assign bank_load[b] = issue & (is_store | is_store_ac) &
                                  (req.bank == 2'(b));
            sct_gap_counter u_wrw (
                .pclk     (pclk),
                .presetn  (presetn),
                .load     (bank_load[b]),
                .load_val (wrw_cycles(wrw_reg)),
                .idle     (bank_idle[b])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Refresh idle counter
    // ------------------------------------------------------------
    logic rfi_idle;
    wire  rfi_load = issue & (is_refresh | is_self_exit);

    sct_gap_counter u_rfi (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (rfi_load),
        .load_val (rfi_cycles(rfi_reg)),
        .idle     (rfi_idle)
    );

    // ------------------------------------------------------------
    // Issue gate: a command waits until every counter it depends on is idle
    // ------------------------------------------------------------
    wire bank_ok   = bank_idle[req.bank];
    wire wrw_block = (is_row_open | is_close) & ~bank_ok;
    wire rfi_block = (is_row_open | is_refresh | is_mode_set) & ~rfi_idle;
    wire cmd_ok    = (req.cmd != SCT_CMD_NOP);

    assign issue = take_try & cmd_ok & ~wrw_block & ~rfi_block;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_reg     <= 1'b0;
            cmd_valid_reg <= 1'b0;
            cmd_reg       <= '{cmd: SCT_CMD_NOP, bank: 2'h0};
        end else begin
            taken_reg     <= issue;
            cmd_valid_reg <= issue;
            cmd_reg       <= issue ? req : '{cmd: SCT_CMD_NOP, bank: 2'h0};
        end
    end

    // ------------------------------------------------------------
    // Read data strobe after programmed latency
    // ------------------------------------------------------------
    wire [SCT_RD_PIPE-1:0] rd_pipe_next = {rd_pipe_reg[SCT_RD_PIPE-2:0], issue & is_read};
    wire                   rd_strobe_next = rd_pipe_reg[rdlat_reg];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_pipe_reg   <= '0;
            rd_strobe_reg <= 1'b0;
            lat_out_reg   <= SCT_RDLAT_RESET;
        end else begin
            rd_pipe_reg   <= rd_pipe_next;
            rd_strobe_reg <= rd_strobe_next;
            lat_out_reg   <= rdlat_reg;
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    assign status_word = {26'h0, (|rd_pipe_reg), ~rfi_idle, ~bank_idle};

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign req_taken          = taken_reg;
    assign mem_cmd_valid      = cmd_valid_reg;
    assign mem_cmd            = cmd_reg;
    assign read_data_strobe   = rd_strobe_reg;
    assign area3_read_latency = lat_out_reg;

endmodule

// ===== sim/sct_spacing_checker.sv
`timescale 1ns/100ps

module sct_spacing_checker
    import sct_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        req_valid,
    input wire logic        req_taken,
    input wire logic        mem_cmd_valid,
    input wire sct_req_t    mem_cmd,
    input wire logic        read_data_strobe,
    input wire logic [1:0]  area3_read_latency
);
    // ----
    // Shadow of the programmed waits
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [1:0] wrw_c, rfi_c, wbank;
    logic [3:0] wcnt, rcnt;
    wire cmt = psel && penable && pwrite && pready && !pslverr && paddr == SCT_TIMING_OFF;
    wire [3:0] op = mem_cmd_valid ? mem_cmd.cmd : SCT_CMD_NOP;
    wire v_rf = op == SCT_CMD_REFRESH || op == SCT_CMD_SELF_EXIT;
    wire v_st = op == SCT_CMD_COLUMN_STORE || op == SCT_CMD_COLUMN_STORE_AC;
    wire [3:0] m_cyc = rfi_c == 2'h0 ? SCT_RFI_CYC0 : rfi_c == 2'h1 ? SCT_RFI_CYC1 :
                       rfi_c == 2'h2 ? SCT_RFI_CYC2 : SCT_RFI_CYC3;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {wrw_c, rfi_c, wbank, wcnt, rcnt} <= '0;
        end else begin
            if (cmt) {wrw_c, rfi_c} <= {pwdata[4:3], pwdata[1:0]};
            if (v_st) wbank <= mem_cmd.bank;
            rcnt <= v_rf ? m_cyc : rcnt - 4'(rcnt != 0);
            wcnt <= v_st ? {2'h0, wrw_c} : wcnt - 4'(wcnt != 0);
        end
    end
    AST_APB_WAIT: assert property ($rose(penable) && psel |=> pready) else $error("pready late");
    AST_UNMAPPED: assert property (pready && paddr != SCT_TIMING_OFF && paddr != SCT_STATUS_OFF |-> pslverr)
        else $error("no slverr");
    AST_RSV_ZERO: assert property (pready && !pwrite && paddr == SCT_TIMING_OFF |->
        prdata[31:9] == 0 && prdata[6:5] == 0 && !prdata[2]) else $error("reserved bit set");
    AST_TAKE_CMD: assert property (req_taken || mem_cmd_valid |->
        req_taken && mem_cmd_valid && $past(req_valid)) else $error("take and issue apart");
    AST_NO_NOP: assert property (mem_cmd_valid |-> mem_cmd.cmd != SCT_CMD_NOP) else $error("nop issued");
    AST_CMD_GAP: assert property (mem_cmd_valid |=> !mem_cmd_valid) else $error("commands too close");
    AST_RD_LAT0: assert property (op == SCT_CMD_COLUMN_READ && area3_read_latency == 2'h0
        |=> read_data_strobe) else $error("latency 1 missed");
    AST_RD_LAT2: assert property (op == SCT_CMD_COLUMN_READ && area3_read_latency == 2'h2
        |-> !read_data_strobe ##2 !read_data_strobe ##1 read_data_strobe) else $error("latency 3 missed");
    AST_RFI_IDLE: assert property ((op == SCT_CMD_ROW_OPEN || op == SCT_CMD_REFRESH
        || op == SCT_CMD_MODE_SET) |-> rcnt == 0) else $error("refresh idle cut short");
    AST_WRW_WAIT: assert property ((op == SCT_CMD_ROW_OPEN || op == SCT_CMD_BANK_CLOSE)
        && mem_cmd.bank == wbank |-> wcnt == 0) else $error("write recovery cut short");
endmodule

bind sct_spacing sct_spacing_checker u_sct_spacing_checker (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_taken, .mem_cmd_valid, .mem_cmd,
    .read_data_strobe, .area3_read_latency);

// ===== sim/sct_mem_model.sv
`timescale 1ns/100ps

module sct_mem_model
    import sct_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire logic [1:0] ap_delay,
    input  wire logic     mem_cmd_valid,
    input  wire sct_req_t mem_cmd,
    output logic          clash
);
    // ----
    // Internal autoclose start after a store with autoclose (SCT_CMD_COLUMN_STORE_AC only)
    // ----
    int         pend;
    logic [1:0] pbank;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pend, pbank, clash} <= '0;
        end else if (mem_cmd_valid && mem_cmd.cmd == SCT_CMD_COLUMN_STORE_AC) begin
            pend  <= int'(ap_delay);
            pbank <= mem_cmd.bank;
        end else begin
            pend <= pend - int'(pend != 0);
            if (mem_cmd_valid && mem_cmd.cmd == SCT_CMD_ROW_OPEN && mem_cmd.bank == pbank && pend != 0) clash <= 1;
        end
    end
endmodule

// ===== sim/tb.sv
`timescale 1ns/100ps

module tb
    import sct_pkg::*;
;
    // ----
    // Design, far side and stimulus state
    // ----
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req_valid = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, lf = 32'h9617, w;
    sct_req_t    req = '0, mem_cmd;
    logic [31:0] prdata;
    logic        pready, pslverr, req_taken, mem_cmd_valid, read_data_strobe, clash;
    logic [1:0]  area3_read_latency, b, apd = '0;
    logic [33:0] e, rq[$];
    sct_req_t    cq[$];
    int          mq[$], sq[$], err_count = 0, cmp_count = 0, cyc = 0, last = 0, k, m, m2, lat;

    sct_spacing u_sct_spacing (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .req_valid, .req, .req_taken, .mem_cmd_valid, .mem_cmd, .read_data_strobe, .area3_read_latency);
    sct_mem_model u_sct_mem_model (.pclk, .presetn, .ap_delay(apd), .mem_cmd_valid, .mem_cmd, .clash);

    always #4 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
        rq.push_back({wr, x});
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(negedge pclk); while (pready !== 1'b1);
        @(posedge pclk);
        {psel, penable} <= 2'b00;
    endtask

    // Gap of 0 means timing is free; else cycles after the previous take, raised to 3 when smaller
    task automatic cmd(input sct_cmd_t c, input logic [1:0] bk, input int gap);
        cq.push_back(sct_req_t'{c, bk});
        mq.push_back(gap == 0 ? -1 : last + (gap > 3 ? gap : 3));
        @(posedge pclk);
        req_valid <= 1;
        req       <= sct_req_t'{c, bk};
        do @(negedge pclk); while (req_taken !== 1'b1);
        last = cyc;
        if (c == SCT_CMD_COLUMN_READ) sq.push_back(cyc + lat + 1);
        @(posedge pclk);
        req_valid <= 0;
    endtask

    always @(negedge pclk) begin
        if (pready === 1'b1) begin
            e = rq.pop_front();
            chk_val(pslverr, e[32], "slverr");
            if (!e[33]) chk_val(prdata, e[31:0], "read data");
        end
        if (mem_cmd_valid === 1'b1) begin
            chk_val(mem_cmd, cq.pop_front(), "command");
            m2 = mq.pop_front();
            if (m2 >= 0) chk_val(cyc, m2, "command cycle");
        end
        if (read_data_strobe === 1'b1) chk_val(cyc, sq.pop_front(), "strobe cycle");
    end

    task report_and_stop;
        $display("Mismatches %0d, comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        apb(0, SCT_TIMING_OFF, 0, {1'b0, SCT_TIMING_RESET});
        apb(0, SCT_STATUS_OFF, 0, 33'h0);
        apb(1, 12'h008, 32'hffffffff, 33'h100000000);
        apb(0, 12'h008, 0, 33'h100000000);
        apb(1, SCT_TIMING_OFF, 32'hffffffff, 33'h0);
        apb(0, SCT_TIMING_OFF, 0, 33'h19b);
        for (k = 0; k < 4; k++) begin
            lf  = lfsr(lf);
            b   = lf[1:0];
            w   = (k << 7) | (k << 3) | k;
            m   = k == 0 ? 2 : k == 1 ? 3 : k == 2 ? 5 : 8;
            lat = k;
            apd <= 2'(k);
            apb(1, SCT_TIMING_OFF, (lf & 32'hfffffe64) | w, 33'h0);
            apb(0, SCT_TIMING_OFF, 0, {1'b0, w});
            @(negedge pclk);
            chk_val(area3_read_latency, k, "area3 latency");
            cmd(SCT_CMD_COLUMN_READ, b, 0);
            cmd(SCT_CMD_COLUMN_STORE_AC, b, 0);
            cmd(SCT_CMD_ROW_OPEN, b, k + 1);
            cmd(SCT_CMD_COLUMN_STORE, b + 2'd1, 0);
            cmd(SCT_CMD_BANK_CLOSE, b + 2'd1, k + 1);
            cmd(SCT_CMD_REFRESH, b, 0);
            cmd(SCT_CMD_REFRESH, b, m + 1);
            cmd(SCT_CMD_ROW_OPEN, b + 2'd2, m + 1);
            cmd(SCT_CMD_SELF_EXIT, b, 0);
            cmd(SCT_CMD_MODE_SET, b, m + 1);
        end
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        chk_val(clash, 0, "autoclose clash");
        chk_val(rq.size() + cq.size() + mq.size() + sq.size(), 0, "pending notes");
        report_and_stop();
    end
endmodule
